/* inc/cifs_pkg.sv */
// Purpose: Shared constants for the current input fault selector
// Assumes: 200 MHz measurement clock, 24-bit signed current and voltage samples
// Notes: Register indexes are word indexes; byte address is four times the index
package cifs_pkg;

  // ************************************************************
  // Register map (word indexes)
  // ************************************************************
  localparam logic [7:0] ACC_MODE_IDX = 8'h0F; // accumulation_mode
  localparam logic [7:0] GAIN_TRIM_IDX = 8'h1C; // secondary_input_gain_trim
  localparam logic [7:0] CAL_MODE_IDX = 8'h3D; // calibration_mode
  localparam logic [7:0] IRQ_EN_IDX = 8'hD9; // measurement_irq_enable_low
  localparam logic [7:0] IRQ_ST_IDX = 8'hDC; // measurement_irq_status_low

  // ************************************************************
  // Field positions and values
  // ************************************************************
  localparam int SEL_IND_BIT = 7; // selected_input_indicator in accumulation_mode
  localparam int FLAG_MODE_BIT = 6; // fault flag mode in accumulation_mode
  localparam int FAULT_FLAG_BIT = 5; // fault_transition_flag in status and enable
  localparam int FORCE_LO = 4; // forced_input_select low bit in calibration_mode
  localparam logic [1:0] FORCE_PRIMARY = 2'h1;
  localparam logic [1:0] FORCE_SECONDARY = 2'h2;
  localparam int GAIN_W = 12; // Gain trim width, 1/4096 per step
  localparam int GAIN_FRAC = 12; // Gain trim fraction bits
  localparam logic [13:0] GAIN_UNITY = 14'h1000; // Unity gain in trim units

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] ACC_MODE_RST = 8'h00;
  localparam logic [11:0] GAIN_TRIM_RST = 12'h000;
  localparam logic [7:0] CAL_MODE_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;

  // ************************************************************
  // Measurement constants
  // ************************************************************
  localparam int SAMPLE_W = 24; // Input sample width
  localparam int MAG_W = 25; // Trimmed magnitude width
  localparam int FILT_SH = 8; // Averaging filter shift
  localparam int DIFF_SH = 4; // 6.25 percent is one sixteenth
  localparam int FULL_SCALE_CODE = 2147483; // Code for full-scale input
  localparam int VOLT_MIN_PERMILLE = 3; // 0.3 percent of full scale
  localparam logic [MAG_W-1:0] VOLT_MIN = MAG_W'(FULL_SCALE_CODE * VOLT_MIN_PERMILLE / 1000);
  localparam longint CLK_HZ = 200000000; // Measurement clock rate
  localparam longint FAULT_DELAY_S = 3; // Fault decision lag in seconds
  localparam logic [31:0] FAULT_DELAY_CYC = 32'(FAULT_DELAY_S * CLK_HZ);

endpackage

/* hw/cifs_top.sv */
// Purpose: Fault detection and input selection between two current inputs
// Assumes: Samples are synchronous to clk_i; Avalon-MM slave with byte addresses
// Notes: Decisions use averaged magnitudes; secondary input is gain trimmed
// ************************************************************
// Summary of operation
// [RULE1] Fault when inputs differ over active/16
// [RULE2] Fault with larger inactive input swaps input; code swaps to the secondary only when it leads by over a sixteenth of itself
// [RULE3] During fault, measure from larger input; code keeps the primary if the secondary leads by a sixteenth of itself or less
// [RULE4] Primary input selected after power-up
// [RULE5] No fault detection below 0.3% voltage
// [RULE6] Selected input shown in accumulation_mode bit7
// [RULE7] calibration_mode bits5:4 force input selection
// [RULE8] Mode clear: flag on fault entry/exit
// [RULE9] Enabled fault flag raises the interrupt
// [RULE10] Low secondary flags fault, primary kept
// [RULE11] Averaged inputs; decisions lag about three seconds
// [RULE12] Larger secondary flags, swaps after delay; code swaps only if it leads by over a sixteenth of itself
// [RULE13] Return to primary over secondary by 1/16
// [RULE14] Mode set: flag when inputs come close; code flags only while the secondary is active
// [RULE15] Signed 12-bit trim scales secondary input
// [RULE16] Trim applies to all secondary measurements
// [RULE17] Software matches gains via trim register
// [RULE18] Flag stays set until software clears
// ************************************************************
`timescale 1ns/100ps
`default_nettype none
module cifs_top #(
  parameter logic [31:0] FAULT_DELAY = cifs_pkg::FAULT_DELAY_CYC // Lag in cycles
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample streams
  input wire logic sample_valid_i,
  input wire logic signed [23:0] primary_current_i,
  input wire logic signed [23:0] secondary_current_i,
  input wire logic signed [23:0] voltage_i,
  // Avalon-MM slave
  input wire logic [9:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Measurement outputs
  output logic signed [24:0] selected_current_o,
  output logic selected_input_o,
  output logic fault_o,
  output logic irq_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic wait_req; // Avalon waitrequest
    logic [31:0] rdata; // Avalon read data
    logic [6:0] acc_mode; // accumulation_mode bits 6:0
    logic [11:0] gain; // secondary_input_gain_trim
    logic [7:0] cal_mode; // calibration_mode
    logic [7:0] irq_en; // measurement_irq_enable_low
    logic [7:0] irq_st; // measurement_irq_status_low
    logic irq; // Interrupt line
    logic [32:0] acc_a; // Primary average accumulator
    logic [32:0] acc_b; // Secondary average accumulator
    logic [32:0] acc_v; // Voltage average accumulator
    logic [31:0] cnt; // Persistence counter
    logic fault; // Fault state
    logic auto_sel; // Automatic selection, 1 = secondary
    logic near; // Inputs within one sixteenth
    logic sel; // Effective selection
    logic signed [24:0] sel_cur; // Selected current sample
  } cifs_state_t;

  cifs_state_t s_q; // Registered state
  cifs_state_t s_d; // Next state

  // Combinational helpers
  logic signed [38:0] b_prod; // Secondary times trim factor
  logic signed [24:0] b_trim; // Trimmed secondary sample
  logic [24:0] mag_a; // Primary sample magnitude
  logic [24:0] mag_b; // Trimmed secondary magnitude
  logic [24:0] mag_v; // Voltage magnitude
  logic [24:0] avg_a; // Averaged primary
  logic [24:0] avg_b; // Averaged secondary
  logic [24:0] avg_v; // Averaged voltage
  logic [24:0] diff; // Absolute difference of averages
  logic [24:0] thr_act; // One sixteenth of active input
  logic [24:0] thr_b; // One sixteenth of secondary
  logic volt_ok; // Voltage above detection floor
  logic fault_raw; // Instantaneous fault decision
  logic swap_want; // Secondary should take over
  logic back_want; // Primary should take back
  logic pending; // A decision awaits the lag
  logic set_flag; // Fault transition event
  logic [1:0] force_sel; // forced_input_select
  logic [7:0] idx; // Register word index
  logic [31:0] rd_mux; // Read data mux

  // ************************************************************
  // Trim, magnitudes and averages
  // ************************************************************
  // Secondary is scaled by (4096 + trim) / 4096 before any use
  always_comb begin
    b_prod = 39'(secondary_current_i) *
      39'($signed({1'b0, cifs_pkg::GAIN_UNITY}) + 39'($signed(s_q.gain))); // RULE15
    b_trim = b_prod[36:12]; // RULE16
    mag_a = primary_current_i[23] ? 25'(-primary_current_i) : 25'(primary_current_i);
    mag_b = b_trim[24] ? 25'(-b_trim) : 25'(b_trim);
    mag_v = voltage_i[23] ? 25'(-voltage_i) : 25'(voltage_i);
    avg_a = s_q.acc_a[32:cifs_pkg::FILT_SH]; // RULE11
    avg_b = s_q.acc_b[32:cifs_pkg::FILT_SH]; // RULE11
    avg_v = s_q.acc_v[32:cifs_pkg::FILT_SH];
  end

  // ************************************************************
  // Fault decisions
  // ************************************************************
  // Compare averaged magnitudes against one sixteenth thresholds
  always_comb begin
    diff = (avg_a > avg_b) ? avg_a - avg_b : avg_b - avg_a;
    thr_act = (s_q.auto_sel ? avg_b : avg_a) >> cifs_pkg::DIFF_SH;
    thr_b = avg_b >> cifs_pkg::DIFF_SH;
    volt_ok = avg_v >= cifs_pkg::VOLT_MIN; // RULE5
    fault_raw = volt_ok && (diff > thr_act); // RULE1
    // Primary active and secondary larger by over a sixteenth of itself
    swap_want = volt_ok && !s_q.auto_sel && (avg_b > avg_a) && (diff > thr_b); // RULE2 RULE12
    // Secondary active and primary larger by over a sixteenth of secondary
    back_want = volt_ok && s_q.auto_sel && (avg_a > avg_b) && (diff > thr_b); // RULE13
    // Low voltage freezes every decision, fault exit included
    pending = volt_ok && ((fault_raw != s_q.fault) || swap_want || back_want); // RULE5
    force_sel = s_q.cal_mode[cifs_pkg::FORCE_LO +: 2];
    idx = address_i[9:2];
  end

  // ************************************************************
  // Register read mux
  // ************************************************************
  // Unmapped indexes read as zero
  always_comb begin
    case (idx)
      cifs_pkg::ACC_MODE_IDX: begin
        rd_mux = {24'h000000, s_q.sel, s_q.acc_mode}; // RULE6
      end
      cifs_pkg::GAIN_TRIM_IDX: begin
        rd_mux = {20'h00000, s_q.gain};
      end
      cifs_pkg::CAL_MODE_IDX: begin
        rd_mux = {24'h000000, s_q.cal_mode};
      end
      cifs_pkg::IRQ_EN_IDX: begin
        rd_mux = {24'h000000, s_q.irq_en};
      end
      cifs_pkg::IRQ_ST_IDX: begin
        rd_mux = {24'h000000, s_q.irq_st};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  // One pass builds the whole next state; the register below only copies it
  always_comb begin
    s_d = s_q;
    set_flag = 1'b0;
    // Averaging filters advance on each sample
    if (sample_valid_i) begin
      s_d.acc_a = s_q.acc_a + 33'(mag_a) - 33'(avg_a); // RULE11
      s_d.acc_b = s_q.acc_b + 33'(mag_b) - 33'(avg_b); // RULE11
      s_d.acc_v = s_q.acc_v + 33'(mag_v) - 33'(avg_v);
      s_d.sel_cur = s_q.sel ? b_trim : 25'(primary_current_i); // RULE3 RULE16
    end
    // Decisions must persist for the full lag before they act
    if (!pending) begin
      s_d.cnt = 32'h00000000;
    end else if (s_q.cnt >= FAULT_DELAY - 32'h00000001) begin
      s_d.cnt = 32'h00000000; // RULE11
      s_d.fault = fault_raw;
      // Entry or exit of fault, including low secondary case
      if ((fault_raw != s_q.fault) && !s_q.acc_mode[cifs_pkg::FLAG_MODE_BIT]) begin
        set_flag = 1'b1; // RULE8 RULE10
      end
      if (swap_want) begin
        s_d.auto_sel = 1'b1; // RULE2 RULE12
      end else if (back_want) begin
        s_d.auto_sel = 1'b0; // RULE13
      end
    end else begin
      s_d.cnt = s_q.cnt + 32'h00000001;
    end
    // Flag as soon as the primary comes close while secondary is active
    s_d.near = volt_ok && (diff <= thr_b);
    if (s_q.acc_mode[cifs_pkg::FLAG_MODE_BIT] && s_q.auto_sel && s_d.near && !s_q.near) begin
      set_flag = 1'b1; // RULE14
    end
    // Forced selection overrides the automatic choice
    if (force_sel == cifs_pkg::FORCE_PRIMARY) begin
      s_d.sel = 1'b0; // RULE7
    end else if (force_sel == cifs_pkg::FORCE_SECONDARY) begin
      s_d.sel = 1'b1; // RULE7
    end else begin
      s_d.sel = s_d.auto_sel; // RULE4
    end
    // Avalon: first cycle of a request lowers waitrequest, second commits
    if ((read_i || write_i) && s_q.wait_req) begin
      s_d.wait_req = 1'b0;
      s_d.rdata = rd_mux;
    end else if (!s_q.wait_req) begin
      s_d.wait_req = 1'b1;
      s_d.rdata = 32'h00000000;
      if (write_i) begin
        case (idx)
          cifs_pkg::ACC_MODE_IDX: begin
            s_d.acc_mode = writedata_i[6:0];
          end
          cifs_pkg::GAIN_TRIM_IDX: begin
            s_d.gain = writedata_i[cifs_pkg::GAIN_W-1:0]; // RULE17
          end
          cifs_pkg::CAL_MODE_IDX: begin
            s_d.cal_mode = writedata_i[7:0];
          end
          cifs_pkg::IRQ_EN_IDX: begin
            s_d.irq_en = writedata_i[7:0];
          end
          cifs_pkg::IRQ_ST_IDX: begin
            s_d.irq_st = s_q.irq_st & ~writedata_i[7:0]; // RULE18
          end
          default: begin
            s_d.irq_st = s_d.irq_st;
          end
        endcase
      end
    end
    // Setting wins over a clear in the same cycle
    if (set_flag) begin
      s_d.irq_st[cifs_pkg::FAULT_FLAG_BIT] = 1'b1; // RULE18
    end
    s_d.irq = |(s_d.irq_st & s_d.irq_en); // RULE9
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset loads constants only, so power-up bills on the primary input
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.wait_req <= 1'b1;
      s_q.acc_mode <= cifs_pkg::ACC_MODE_RST[6:0];
      s_q.gain <= cifs_pkg::GAIN_TRIM_RST;
      s_q.cal_mode <= cifs_pkg::CAL_MODE_RST;
      s_q.irq_en <= cifs_pkg::IRQ_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign readdata_o = s_q.rdata;
  assign waitrequest_o = s_q.wait_req;
  assign selected_current_o = s_q.sel_cur;
  assign selected_input_o = s_q.sel;
  assign fault_o = s_q.fault;
  assign irq_o = s_q.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  // Forcing the primary wins over the automatic choice
  force_primary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    (force_sel == cifs_pkg::FORCE_PRIMARY) |=> !selected_input_o)
    else $error("forced primary not selected");
  // Forcing the secondary wins over the automatic choice
  force_secondary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    (force_sel == cifs_pkg::FORCE_SECONDARY) |=> selected_input_o)
    else $error("forced secondary not selected");
  // Codes 00 and 11 hand selection back to fault detection
  auto_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    (force_sel != cifs_pkg::FORCE_PRIMARY && force_sel != cifs_pkg::FORCE_SECONDARY)
    |=> (selected_input_o == s_q.auto_sel))
    else $error("automatic selection not followed");
  // Only the fault flag is ever set, so the line is flag and enable
  irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE9
    irq_o == (s_q.irq_st[cifs_pkg::FAULT_FLAG_BIT] && s_q.irq_en[cifs_pkg::FAULT_FLAG_BIT]))
    else $error("interrupt does not follow enabled flags");
  // Only a write of one at the commit edge may drop the flag
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE18
    (s_q.irq_st[cifs_pkg::FAULT_FLAG_BIT] && !(write_i && !waitrequest_o &&
    idx == cifs_pkg::IRQ_ST_IDX)) |=> s_q.irq_st[cifs_pkg::FAULT_FLAG_BIT])
    else $error("fault flag dropped without a clear");
  // No decision is even proposed under the voltage floor
  low_volt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    !volt_ok |-> !fault_raw && !swap_want && !back_want)
    else $error("fault detection active at low voltage");
  // Fault state and selection freeze under the voltage floor
  fault_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    !volt_ok |=> $stable(fault_o) && $stable(s_q.auto_sel))
    else $error("fault state moved at low voltage");
  // Nothing acts before the persistence counter runs out
  lag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
    (s_q.cnt < FAULT_DELAY - 32'h00000001) |=> $stable(fault_o) && $stable(s_q.auto_sel))
    else $error("decision acted before lag");
  // With the mode bit clear every entry and exit is flagged
  mode_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
    ($changed(fault_o) && !$past(s_q.acc_mode[cifs_pkg::FLAG_MODE_BIT]))
    |-> s_q.irq_st[cifs_pkg::FAULT_FLAG_BIT])
    else $error("fault transition not flagged");
  // With the mode bit set and the secondary active, closing inputs flag at once
  close_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE14
    (s_q.acc_mode[cifs_pkg::FLAG_MODE_BIT] && s_q.auto_sel && s_d.near && !s_q.near)
    |=> s_q.irq_st[cifs_pkg::FAULT_FLAG_BIT])
    else $error("close inputs not flagged");
  // A move to the secondary needs a larger secondary
  swap_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    $rose(s_q.auto_sel) |-> $past(swap_want))
    else $error("secondary taken without cause");
  // A smaller secondary never takes billing from the primary
  keep_primary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
    (!s_q.auto_sel && (avg_b <= avg_a)) |=> !s_q.auto_sel)
    else $error("billing left the larger primary");
  // The primary returns only when it is the larger one
  return_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE13
    (s_q.auto_sel && (avg_a <= avg_b)) |=> s_q.auto_sel)
    else $error("primary returned while smaller");
  // Selected secondary samples carry the gain trim
  trim_path_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE16
    (sample_valid_i && selected_input_o) |=> (selected_current_o == $past(b_trim)))
    else $error("secondary sample passed untrimmed");
  // Every taken request is answered on the next edge
  answer_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((read_i || write_i) && waitrequest_o) |=> !waitrequest_o)
    else $error("request not answered in one cycle");
  // The answer stands for a single cycle
  wait_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    waitrequest_o |-> (readdata_o == 32'h00000000))
    else $error("read data outside the answer cycle");

endmodule
`default_nettype wire

/* verification/cifs_sensor_model.sv */
// Purpose: Phase, neutral and voltage sensor streams for the fault selector
// Assumes: Square wave of the given amplitudes, one sample gap in four
// Notes: Lines invert every cycle while no sample is valid, starting from the last sample
`timescale 1ns/100ps
`default_nettype none
module cifs_sensor_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Amplitude control from the bench
  input wire logic hold_i,
  input wire logic signed [23:0] p_amp_i,
  input wire logic signed [23:0] s_amp_i,
  input wire logic signed [23:0] v_amp_i,
  // Sample streams
  output logic sample_valid_o,
  output logic signed [23:0] primary_o,
  output logic signed [23:0] secondary_o,
  output logic signed [23:0] voltage_o,
  output logic last_neg_o
);
  // ****
  // State
  // ****
  typedef struct packed {
    logic [1:0] cnt;
    logic valid;
    logic neg;
    logic last_neg;
    logic signed [23:0] p;
    logic signed [23:0] s;
    logic signed [23:0] v;
  } cifs_sens_t;
  cifs_sens_t q, d; // Registered state and its next value
  // Next sample, or garbage while idle so stale data never looks valid
  always_comb begin
    d = q;
    d.cnt = q.cnt + 2'h1;
    d.valid = !hold_i && (q.cnt != 2'h3);
    if (d.valid) begin
      d.p = q.neg ? -p_amp_i : p_amp_i;
      d.s = q.neg ? -s_amp_i : s_amp_i;
      d.v = q.neg ? -v_amp_i : v_amp_i;
      d.last_neg = q.neg;
      d.neg = ~q.neg;
    end else begin
      d.p = ~q.p;
      d.s = ~q.s;
      d.v = ~q.v;
    end
  end
  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) q <= '0;
    else q <= d;
  end
  assign sample_valid_o = q.valid;
  assign primary_o = q.p;
  assign secondary_o = q.s;
  assign voltage_o = q.v;
  assign last_neg_o = q.last_neg;
endmodule
`default_nettype wire

/* verification/test_current_input_fault_selector.sv */
// Purpose: Self-checking bench for the fault selector
// Assumes: Sensor model feeds the samples; software side is the bus tasks
// Notes: Fault lag shortened to 16 cycles
`timescale 1ns/100ps
`default_nettype none
module test_current_input_fault_selector;
  // ****
  // Signals
  // ****
  logic clk_i, rst_n_i, read_i, write_i, hold, waitrequest_o, irq_o;
  logic selected_input_o, fault_o, sv, ln;
  logic [9:0] address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic signed [23:0] pa, sa, va, pc, sc, vc;
  logic signed [24:0] selected_current_o;
  logic [7:0] rows [6] = '{8'h0F, 8'h1C, 8'h3D, 8'hD9, 8'hDC, 8'h10}; // Register index
  logic [31:0] exps [6] = '{32'h7F, 32'hFFF, 32'hFF, 32'hFF, 32'h0, 32'h0}; // Read back
  logic [11:0] trims [3] = '{12'h000, 12'h800, 12'h7FF};
  int num_errors, checked, i;
  longint e;
  cifs_sensor_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .hold_i(hold), .p_amp_i(pa),
    .s_amp_i(sa), .v_amp_i(va), .sample_valid_o(sv), .primary_o(pc), .secondary_o(sc),
    .voltage_o(vc), .last_neg_o(ln));
  cifs_top #(.FAULT_DELAY(32'd16)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sample_valid_i(sv), .primary_current_i(pc), .secondary_current_i(sc), .voltage_i(vc),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .selected_current_o(selected_current_o), .selected_input_o(selected_input_o),
    .fault_o(fault_o), .irq_o(irq_o));
  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon cycle; data taken at the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= {idx, 2'h0};
    writedata_i <= wd;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    check("wait", {31'h0, s}, {31'h0, v});
  endtask
  task automatic amp(input int p, input int s, input int v);
    @(posedge clk_i);
    pa <= 24'(p);
    sa <= 24'(s);
    va <= 24'(v);
  endtask
  task automatic flag(input logic [31:0] exp);
    bus(1'b0, 8'hDC, 32'h0);
    check("fault flag", rd & 32'h20, exp);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Clock at 200 MHz
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {rst_n_i, read_i, write_i, hold, address_i, writedata_i} = '0;
    {num_errors, checked} = '0;
    pa = 24'sd1000000;
    sa = 24'sd1000000;
    va = 24'sd1000000;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    check("idle", {30'h0, waitrequest_o, irq_o}, 32'h2);
    check("select", {31'h0, selected_input_o}, 32'h0);
    // Reset value, write all ones, read back; bit 7 stays read only
    for (i = 0; i < 6; i++) begin
      bus(1'b0, rows[i], 32'h0);
      check("reset", rd, 32'h0);
      bus(1'b1, rows[i], 32'hFFF);
      bus(1'b0, rows[i], 32'h0);
      check("readback", rd, exps[i]);
    end
    check("irq", {31'h0, irq_o}, 32'h0);
    for (i = 0; i < 6; i++) bus(1'b1, rows[i], 32'h0);
    // Forced secondary with each trim; secondary twice primary
    amp(1048576, 2097152, 1000000);
    bus(1'b1, 8'h3D, 32'h20);
    for (i = 0; i < 3; i++) begin
      bus(1'b1, 8'h1C, {20'h0, trims[i]});
      @(posedge clk_i) hold <= 1'b1;
      repeat (4) @(negedge clk_i);
      e = longint'(2097152) * (4096 + longint'($signed(trims[i]))) / 4096;
      if (ln) e = -e;
      check("trimmed", 32'(selected_current_o), 32'(e));
      @(posedge clk_i) hold <= 1'b0;
    end
    bus(1'b0, 8'h0F, 32'h0);
    check("indicator", rd & 32'h80, 32'h80);
    bus(1'b1, 8'h3D, 32'h10);
    wait_for(selected_input_o, 1'b0);
    // Mid-run reset: selection back on primary, registers cleared
    @(posedge clk_i) rst_n_i <= 1'b0;
    amp(1000000, 1000000, 100);
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    check("reset again", {28'h0, waitrequest_o, fault_o, selected_input_o, irq_o}, 32'h8);
    bus(1'b0, 8'h0F, 32'h0);
    check("reset mode", rd, 32'h0);
    bus(1'b1, 8'h3D, 32'h30);
    bus(1'b1, 8'h1C, 32'h0);
    bus(1'b1, 8'hDC, 32'h20);
    bus(1'b1, 8'hD9, 32'h20);
    // Large secondary under light voltage is ignored
    amp(1000000, 1000000, 100);
    repeat (6000) @(posedge clk_i);
    amp(1000000, 1300000, 100);
    repeat (6000) @(posedge clk_i);
    check("no fault", {30'h0, fault_o, selected_input_o}, 32'h0);
    flag(32'h0);
    // Voltage back: swap to the larger secondary
    amp(1000000, 1300000, 1000000);
    wait_for(selected_input_o, 1'b1);
    check("fault", {30'h0, fault_o, irq_o}, 32'h3);
    flag(32'h20);
    bus(1'b1, 8'hD9, 32'h0);
    check("masked", {31'h0, irq_o}, 32'h0);
    bus(1'b1, 8'hD9, 32'h20);
    check("held", {31'h0, irq_o}, 32'h1);
    bus(1'b1, 8'hDC, 32'h20);
    flag(32'h0);
    // Equal inputs end the fault but keep the secondary
    amp(1300000, 1300000, 1000000);
    wait_for(fault_o, 1'b0);
    check("stay", {31'h0, selected_input_o}, 32'h1);
    flag(32'h20);
    bus(1'b1, 8'hDC, 32'h20);
    amp(1450000, 1300000, 1000000);
    wait_for(selected_input_o, 1'b0);
    amp(1000000, 1000000, 1000000);
    wait_for(fault_o, 1'b0);
    bus(1'b1, 8'hDC, 32'h20);
    // Low secondary flags a fault but billing stays on primary
    amp(1000000, 800000, 1000000);
    wait_for(fault_o, 1'b1);
    check("keep", {31'h0, selected_input_o}, 32'h0);
    flag(32'h20);
    amp(1000000, 1000000, 1000000);
    wait_for(fault_o, 1'b0);
    // Flag mode set: flag as soon as primary comes close
    bus(1'b1, 8'h0F, 32'h40);
    amp(1000000, 1300000, 1000000);
    wait_for(selected_input_o, 1'b1);
    bus(1'b1, 8'hDC, 32'h20);
    amp(1300000, 1300000, 1000000);
    i = 0;
    do begin
      bus(1'b0, 8'hDC, 32'h0);
      i++;
    end while (rd[5] !== 1'b1 && i < 3000);
    check("close flag", rd & 32'h20, 32'h20);
    end_of_test();
  end
endmodule
`default_nettype wire
